// ===== ulm_status.sv
/*
 * Serial receiver with receive store, line_status and modem_status
 * registers, modem input sampling and loopback, reached over APB.
 * Assumes one clock, asynchronous active-low reset, pins from outside
 * the clock domain, and an APB master on the same clock.
 */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ulm_consts.svh"

module ulm_status
	import ulm_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxIn,
	input wire logic dcdInN,
	input wire logic ringInN,
	input wire logic ctsInN,
	output logic rtsOutN
);

	localparam int PW = $clog2(FIFO_DEPTH);

	// the store needs a power-of-two depth for its wrapping pointers
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
		$error("FIFO_DEPTH must be a power of two of at least 2");
	end

	//////////////////////////////////////////////////////////////////////
	// apb decode

	logic [31:0] prdata_reg;
	logic setupPhase;
	logic accessPhase;
	logic wrAccess;
	logic rdAccess;
	logic hitRxHold;
	logic hitDivisor;
	logic hitFifoCtrl;
	logic hitLineCtrl;
	logic hitModemCtrl;
	logic hitLineStatus;
	logic hitModemStatus;
	logic addrHit;

	// address decode and phase qualifiers
	assign hitRxHold = paddr == `ULM_ADDR_RX_HOLD;
	assign hitDivisor = paddr == `ULM_ADDR_DIVISOR;
	assign hitFifoCtrl = paddr == `ULM_ADDR_FIFO_CTRL;
	assign hitLineCtrl = paddr == `ULM_ADDR_LINE_CTRL;
	assign hitModemCtrl = paddr == `ULM_ADDR_MODEM_CTRL;
	assign hitLineStatus = paddr == `ULM_ADDR_LINE_STATUS;
	assign hitModemStatus = paddr == `ULM_ADDR_MODEM_STATUS;
	assign addrHit = hitRxHold | hitDivisor | hitFifoCtrl | hitLineCtrl
		| hitModemCtrl | hitLineStatus | hitModemStatus;
	assign setupPhase = psel & ~penable;
	assign accessPhase = psel & penable;
	assign wrAccess = accessPhase & pwrite & addrHit;
	assign rdAccess = accessPhase & ~pwrite & addrHit;

	// zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = accessPhase & ~addrHit;
	assign prdata = prdata_reg;

	//////////////////////////////////////////////////////////////////////
	// control registers

	logic [7:0] modemCtrl_reg;
	logic [7:0] lineCtrl_reg;
	logic fifoEn_reg;
	logic [15:0] divisor_reg;
	logic loopback;
	logic parEn;
	logic evenPar;
	logic fifoModeChange;

	assign loopback = modemCtrl_reg[`ULM_MC_LOOP];
	assign parEn = lineCtrl_reg[`ULM_LC_PAR_EN];
	assign evenPar = lineCtrl_reg[`ULM_LC_EVEN_PAR];
	assign fifoModeChange = wrAccess & hitFifoCtrl
		& (pwdata[`ULM_FC_FIFO_EN] != fifoEn_reg);

	// software writes to the control registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			modemCtrl_reg <= `ULM_CTRL_RESET;
			lineCtrl_reg <= `ULM_CTRL_RESET;
			fifoEn_reg <= 1'b0;
			divisor_reg <= `ULM_DIV_RESET;
		end else if (wrAccess) begin
			if (hitModemCtrl)
				modemCtrl_reg <= {3'h0, pwdata[4:0]};
			if (hitLineCtrl)
				lineCtrl_reg <= pwdata[7:0];
			if (hitFifoCtrl)
				fifoEn_reg <= pwdata[`ULM_FC_FIFO_EN];
			if (hitDivisor)
				divisor_reg <= pwdata[15:0];
		end
	end

	// rts pin follows the control bit, held inactive in loopback
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			rtsOutN <= 1'b1;
		else
			rtsOutN <= loopback | ~modemCtrl_reg[`ULM_MC_RTS];
	end

	//////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] rxSyncChain_reg;
	logic [1:0] dcdSyncChain_reg;
	logic [1:0] ringSyncChain_reg;
	logic [1:0] ctsSyncChain_reg;
	logic rxLine;

	// two stages each; only stage 1 is read by logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxSyncChain_reg <= 2'h3;
			dcdSyncChain_reg <= 2'h3;
			ringSyncChain_reg <= 2'h3;
			ctsSyncChain_reg <= 2'h3;
		end else begin
			rxSyncChain_reg <= {rxSyncChain_reg[0], rxIn};
			dcdSyncChain_reg <= {dcdSyncChain_reg[0], dcdInN};
			ringSyncChain_reg <= {ringSyncChain_reg[0], ringInN};
			ctsSyncChain_reg <= {ctsSyncChain_reg[0], ctsInN};
		end
	end
	assign rxLine = rxSyncChain_reg[1];

	//////////////////////////////////////////////////////////////////////
	// serial receiver, 16 ticks per bit, 8 data bits

	ulm_rx_state_t rxState_reg, rxState_next;
	logic [15:0] divCnt_reg;
	logic [3:0] tickCnt_reg, tickCnt_next;
	logic [2:0] bitCnt_reg, bitCnt_next;
	logic [7:0] shift_reg, shift_next;
	logic parBit_reg, parBit_next;
	logic tick;
	logic bitMid;
	logic charDone;
	logic isBreak;
	logic parMismatch;
	ulm_rx_char_t rxChar;

	// baud tick from the divisor; zero behaves as one
	assign tick = divCnt_reg >= divisor_reg - 16'h0001 || divisor_reg == 16'h0;
	assign bitMid = tick && tickCnt_reg == `ULM_TICKS_LAST;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			divCnt_reg <= 16'h0;
		else
			divCnt_reg <= tick ? 16'h0 : divCnt_reg + 16'h0001;
	end

	// a break is a frame of all zeros, parity and stop included
	assign isBreak = shift_reg == 8'h00 && !(parEn && parBit_reg);
	assign parMismatch = ^{shift_reg, parBit_reg} ^ ~evenPar;
	assign charDone = rxState_reg == RX_STOP && bitMid;

	// character as stored, with its error marks
	assign rxChar.data = shift_reg;
	assign rxChar.breakSeen = isBreak & ~rxLine;
	assign rxChar.framingErr = ~rxLine;
	assign rxChar.parityErr = (parEn & parMismatch) | (isBreak & ~rxLine);

	// receiver sequencing
	always_comb begin
		rxState_next = rxState_reg;
		tickCnt_next = tick ? tickCnt_reg + 4'h1 : tickCnt_reg;
		bitCnt_next = bitCnt_reg;
		shift_next = shift_reg;
		parBit_next = parBit_reg;
		unique case (rxState_reg)
			RX_IDLE: begin
				tickCnt_next = 4'h0;
				if (!rxLine)
					rxState_next = RX_START;
			end
			RX_START: begin
				if (tick && tickCnt_reg == `ULM_TICKS_HALF) begin
					tickCnt_next = 4'h0;
					bitCnt_next = 3'h0;
					rxState_next = rxLine ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (bitMid) begin
					shift_next = {rxLine, shift_reg[7:1]};
					bitCnt_next = bitCnt_reg + 3'h1;
					if (bitCnt_reg == 3'h7)
						rxState_next = parEn ? RX_PARITY : RX_STOP;
				end
			end
			RX_PARITY: begin
				if (bitMid) begin
					parBit_next = rxLine;
					rxState_next = RX_STOP;
				end
			end
			RX_STOP: begin
				if (bitMid) begin
					bitCnt_next = 3'h0;
					if (rxLine)
						rxState_next = RX_IDLE;
					else if (isBreak)
						rxState_next = RX_WAIT_IDLE;
					else
						rxState_next = RX_DATA;
				end
			end
			RX_WAIT_IDLE: begin
				tickCnt_next = 4'h0;
				if (rxLine)
					rxState_next = RX_IDLE;
			end
		endcase
	end

	// receiver state
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rxState_reg <= RX_IDLE;
			tickCnt_reg <= 4'h0;
			bitCnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			parBit_reg <= 1'b0;
		end else begin
			rxState_reg <= rxState_next;
			tickCnt_reg <= tickCnt_next;
			bitCnt_reg <= bitCnt_next;
			shift_reg <= shift_next;
			parBit_reg <= parBit_next;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// receive store: FIFO, or a single holding register without FIFO

	ulm_rx_char_t mem [FIFO_DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [PW:0] count_reg;
	logic headSeen_reg;
	logic pop;
	logic full;
	logic overwrite;
	logic accept;
	logic overrun;
	logic [PW-1:0] wrAddr;
	ulm_rx_char_t head;

	assign pop = rdAccess & hitRxHold & (count_reg != '0);
	assign full = fifoEn_reg ? count_reg == (PW+1)'(FIFO_DEPTH)
		: count_reg != '0;
	assign overrun = charDone & full & ~pop;
	assign overwrite = overrun & ~fifoEn_reg;
	assign accept = charDone & ~(full & ~pop);
	assign wrAddr = overwrite ? rdPtr_reg : wrPtr_reg;
	assign head = mem[rdPtr_reg];

	// character storage
	always_ff @(posedge clk) begin
		if (accept | overwrite)
			mem[wrAddr] <= rxChar;
	end

	// pointers and fill level; a FIFO mode change flushes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else if (fifoModeChange) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= accept ? wrPtr_reg + 1'b1 : wrPtr_reg;
			rdPtr_reg <= pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
			count_reg <= count_reg + (PW+1)'(accept) - (PW+1)'(pop);
		end
	end

	// marks whether the head character's errors were already posted
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			headSeen_reg <= 1'b0;
		else if (pop | overwrite | fifoModeChange)
			headSeen_reg <= 1'b0;
		else if (count_reg != '0)
			headSeen_reg <= 1'b1;
	end

	//////////////////////////////////////////////////////////////////////
	// line_status flags

	logic overrun_reg;
	logic parityFlag_reg;
	logic framingFlag_reg;
	logic headPost;
	logic lineStatusRead;
	logic [7:0] lineStatus;

	// errors reach the flags when their character becomes the head
	assign headPost = count_reg != '0 && !headSeen_reg && !fifoModeChange;
	assign lineStatusRead = rdAccess & hitLineStatus;

	// set wins over the read clear; only bits already reported clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			overrun_reg <= 1'b0;
			parityFlag_reg <= 1'b0;
			framingFlag_reg <= 1'b0;
		end else begin
			overrun_reg <= overrun | (overrun_reg & ~(lineStatusRead
				& prdata_reg[`ULM_LS_OVERRUN]));
			parityFlag_reg <= (headPost & head.parityErr)
				| (parityFlag_reg & ~(lineStatusRead
				& prdata_reg[`ULM_LS_PARITY_ERR]));
			framingFlag_reg <= (headPost & head.framingErr)
				| (framingFlag_reg & ~(lineStatusRead
				& prdata_reg[`ULM_LS_FRAMING_ERR]));
		end
	end

	// upper bits reserved and zero
	assign lineStatus = {4'h0, framingFlag_reg, parityFlag_reg, overrun_reg,
		count_reg != '0};

	//////////////////////////////////////////////////////////////////////
	// modem_status

	ulm_modem_t modemNow;
	logic prevDcd_reg;
	logic prevRing_reg;
	logic dcdChanged_reg;
	logic ringTrail_reg;
	logic modemStatusRead;
	logic [7:0] modemStatus;

	// effective modem levels, loopback substitutes control bits
	assign modemNow.dcd = loopback ? modemCtrl_reg[`ULM_MC_OUTPUT_TWO]
		: ~dcdSyncChain_reg[1];
	assign modemNow.ring = loopback ? modemCtrl_reg[`ULM_MC_OUTPUT_ONE]
		: ~ringSyncChain_reg[1];
	assign modemNow.cts = loopback ? modemCtrl_reg[`ULM_MC_RTS]
		: ~ctsSyncChain_reg[1];
	assign modemStatusRead = rdAccess & hitModemStatus;

	// previous levels reset to deasserted, so an asserted carrier
	// across reset shows as a change once the reset is gone
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prevDcd_reg <= 1'b0;
			prevRing_reg <= 1'b0;
		end else begin
			prevDcd_reg <= modemNow.dcd;
			prevRing_reg <= modemNow.ring;
		end
	end

	// change flags, set wins over the read clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dcdChanged_reg <= 1'b0;
			ringTrail_reg <= 1'b0;
		end else begin
			dcdChanged_reg <= (modemNow.dcd != prevDcd_reg)
				| (dcdChanged_reg & ~(modemStatusRead
				& prdata_reg[`ULM_MS_DCD_CHANGED]));
			ringTrail_reg <= (prevRing_reg & ~modemNow.ring)
				| (ringTrail_reg & ~(modemStatusRead
				& prdata_reg[`ULM_MS_RING_TRAIL]));
		end
	end

	// reserved bits 5, 1, 0 and the upper three bytes read zero
	assign modemStatus = {modemNow.dcd, modemNow.ring, 1'b0, modemNow.cts,
		dcdChanged_reg, ringTrail_reg, 2'h0};

	//////////////////////////////////////////////////////////////////////
	// read data

	logic [31:0] readMux;

	// read value selected in the setup phase
	assign readMux = hitRxHold ? {24'h0, head.data}
		: hitDivisor ? {16'h0, divisor_reg}
		: hitFifoCtrl ? {31'h0, fifoEn_reg}
		: hitLineCtrl ? {24'h0, lineCtrl_reg}
		: hitModemCtrl ? {24'h0, modemCtrl_reg}
		: hitLineStatus ? {24'h0, lineStatus}
		: hitModemStatus ? {24'h0, modemStatus}
		: 32'h0;

	// latched at setup, held through the access phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			prdata_reg <= 32'h0;
		else if (setupPhase)
			prdata_reg <= pwrite ? 32'h0 : readMux;
	end

endmodule // ulm_status
`default_nettype wire

// ===== ulm_consts.svh
/*
 * Register map, field positions, reset values and timing counts of the
 * receive line status and modem status block.
 * Assumes a 32-bit APB with byte addresses and a single 100 MHz clock.
 */
`ifndef ULM_CONSTS_SVH
`define ULM_CONSTS_SVH

// byte addresses of the registers
`define ULM_ADDR_RX_HOLD 32'h5000_1000
`define ULM_ADDR_DIVISOR 32'h5000_1004
`define ULM_ADDR_FIFO_CTRL 32'h5000_1008
`define ULM_ADDR_LINE_CTRL 32'h5000_100c
`define ULM_ADDR_MODEM_CTRL 32'h5000_1010
`define ULM_ADDR_LINE_STATUS 32'h5000_1014
`define ULM_ADDR_MODEM_STATUS 32'h5000_1018

// line_status fields
`define ULM_LS_DATA_READY 0
`define ULM_LS_OVERRUN 1
`define ULM_LS_PARITY_ERR 2
`define ULM_LS_FRAMING_ERR 3

// modem_status fields
`define ULM_MS_RING_TRAIL 2
`define ULM_MS_DCD_CHANGED 3
`define ULM_MS_CTS 4
`define ULM_MS_RING 6
`define ULM_MS_DCD 7

// control fields
`define ULM_MC_RTS 1
`define ULM_MC_OUTPUT_ONE 2
`define ULM_MC_OUTPUT_TWO 3
`define ULM_MC_LOOP 4
`define ULM_LC_PAR_EN 3
`define ULM_LC_EVEN_PAR 4
`define ULM_FC_FIFO_EN 0

// reset values
`define ULM_CTRL_RESET 8'h00
`define ULM_DIV_RESET 16'h0001

// receiver oversampling: ticks per bit and to the middle of the start bit
`define ULM_TICKS_LAST 4'hf
`define ULM_TICKS_HALF 4'h7

`endif

// ===== ulm_pkg.sv
/*
 * Types of the receive line status and modem status block.
 * Assumes ulm_consts.svh carries all numeric constants.
 */
`default_nettype none
package ulm_pkg;

	// one received character as it sits in the receive store
	typedef struct packed {
		logic breakSeen;
		logic framingErr;
		logic parityErr;
		logic [7:0] data;
	} ulm_rx_char_t;

	// effective modem input levels, active high
	typedef struct packed {
		logic dcd;
		logic ring;
		logic cts;
	} ulm_modem_t;

	typedef enum logic [2:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_PARITY,
		RX_STOP,
		RX_WAIT_IDLE
	} ulm_rx_state_t;

endpackage
`default_nettype wire

// ===== ulm_status_sva.sv
/*
 * Checker of ulm_status: status read words, modem levels, change flags
 * and the rts pin.
 * Assumes it is bound to ulm_status and sees its ports only.
 */
`timescale 1ns/1ps
`include "ulm_consts.svh"
`default_nettype none

module ulm_status_sva #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rxIn,
	input wire logic dcdInN,
	input wire logic ringInN,
	input wire logic ctsInN,
	input wire logic rtsOutN
);
	////////////////////////////////////////////////////////////////////////
	// decode of the transfers watched here
	wire logic acc = psel && penable;
	wire logic msRd = acc && !pwrite && paddr == `ULM_ADDR_MODEM_STATUS;
	wire logic lsRd = acc && !pwrite && paddr == `ULM_ADDR_LINE_STATUS;
	wire logic mcWr = acc && pwrite && paddr == `ULM_ADDR_MODEM_CTRL;
	wire logic [2:0] pins = {dcdInN, ringInN, ctsInN};
	logic [2:0] pinsOld;
	logic [2:0] quiet;
	logic [4:0] ctrlCopy;
	logic msClean;
	wire logic moved = pins != pinsOld || mcWr;

	// cycles since a modem pin or modem_control last moved
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pinsOld <= 3'h7;
			quiet <= 3'h0;
			ctrlCopy <= 5'h00;
			msClean <= 1'b0;
		end else begin
			pinsOld <= pins;
			quiet <= moved ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
			if (mcWr)
				ctrlCopy <= pwdata[4:0];
			msClean <= !moved && (msClean || (msRd && quiet > 3'h4));
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	property p_rts_loop;
		ctrlCopy[4] && $past(ctrlCopy[4]) |-> rtsOutN;
	endproperty
	a_rts_loop: assert property (p_rts_loop)
		else $error("rts pin active in loopback");
	property p_rts_pin;
		!ctrlCopy[4] && $stable(ctrlCopy) |-> rtsOutN == !ctrlCopy[1];
	endproperty
	a_rts_pin: assert property (p_rts_pin)
		else $error("rts pin differs from control bit");
	property p_ls_resv;
		lsRd |-> prdata[31:4] == 28'h0;
	endproperty
	a_ls_resv: assert property (p_ls_resv)
		else $error("line status reserved bits set");
	property p_ms_resv;
		msRd |-> prdata[31:8] == 24'h0 && !prdata[5] && prdata[1:0] == 2'h0;
	endproperty
	a_ms_resv: assert property (p_ms_resv)
		else $error("modem status reserved bits set");
	property p_dcd;
		msRd && quiet > 3'h4
			|-> prdata[7] == (ctrlCopy[4] ? ctrlCopy[3] : !dcdInN);
	endproperty
	a_dcd: assert property (p_dcd)
		else $error("carrier level wrong");
	property p_ring;
		msRd && quiet > 3'h4
			|-> prdata[6] == (ctrlCopy[4] ? ctrlCopy[2] : !ringInN);
	endproperty
	a_ring: assert property (p_ring)
		else $error("ring level wrong");
	property p_cts;
		msRd && quiet > 3'h4
			|-> prdata[4] == (ctrlCopy[4] ? ctrlCopy[1] : !ctsInN);
	endproperty
	a_cts: assert property (p_cts)
		else $error("clear to send level wrong");
	property p_delta_clr;
		msRd && msClean && quiet > 3'h4 |-> prdata[3:2] == 2'h0;
	endproperty
	a_delta_clr: assert property (p_delta_clr)
		else $error("change flag survived a read");

	// main scenarios reached
	c_framing: cover property (lsRd && prdata[3]);
	c_overrun: cover property (lsRd && prdata[1]);
	c_dcd_chg: cover property (msRd && prdata[3]);
endmodule // ulm_status_sva

bind ulm_status ulm_status_sva #(.FIFO_DEPTH(FIFO_DEPTH)) sva_u (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rxIn(rxIn), .dcdInN(dcdInN),
	.ringInN(ringInN), .ctsInN(ctsInN), .rtsOutN(rtsOutN)
);
`default_nettype wire

// ===== ulm_line_model.sv
/*
 * Model of the modem or data set: serial frames on the receive line and
 * the three active-low modem lines.
 * Assumes a divisor of 1, so one bit lasts 16 clocks.
 */
`timescale 1ns/1ps
`default_nettype none

module ulm_line_model (
	input wire logic clk,
	output logic rxLine = 1'b1,
	output logic dcdN = 1'b1,
	output logic ringN = 1'b1,
	output logic ctsN = 1'b1
);
	////////////////////////////////////////////////////////////////////////
	// one bit time on the line
	task automatic put_bit(input logic b);
		rxLine <= b;
		repeat (16) @(posedge clk);
	endtask

	// optional start, lsb first, optional parity, stop left on the line
	task automatic frame(input logic [7:0] d, input logic st,
		input logic parOn, input logic par, input logic stp);
		if (st)
			put_bit(1'b0);
		for (int i = 0; i < 8; i++)
			put_bit(d[i]);
		if (parOn)
			put_bit(par);
		put_bit(stp);
	endtask

	// line back to idle high for a gap
	task automatic idle(input int n);
		rxLine <= 1'b1;
		repeat (n + 1) @(posedge clk);
	endtask

	// modem line levels as {carrier, ring, clear to send}
	task automatic pins(input logic [2:0] p);
		{dcdN, ringN, ctsN} <= p;
	endtask
endmodule // ulm_line_model
`default_nettype wire

// ===== ulm_status_tb_top.sv
/*
 * Testbench of ulm_status: APB reads noted in a queue and matched by a
 * monitor, with the line model on the serial and modem pins.
 * Assumes ulm_status, ulm_line_model and the bound checker.
 */
`timescale 1ns/1ps
`include "ulm_consts.svh"
`default_nettype none

module ulm_status_tb_top;
	localparam logic [31:0] A_RX = `ULM_ADDR_RX_HOLD;
	localparam logic [31:0] A_FC = `ULM_ADDR_FIFO_CTRL;
	localparam logic [31:0] A_LC = `ULM_ADDR_LINE_CTRL;
	localparam logic [31:0] A_MC = `ULM_ADDR_MODEM_CTRL;
	localparam logic [31:0] A_LS = `ULM_ADDR_LINE_STATUS;
	localparam logic [31:0] A_MS = `ULM_ADDR_MODEM_STATUS;
	localparam logic [31:0] A_BAD = 32'h5000_1030;
	typedef struct packed {logic [31:0] val, mask; logic err;} ulm_note_t;
	ulm_note_t notes[$];
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] seed = 32'h7a13;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, rxIn, dcdInN, ringInN, ctsInN, rtsOutN;
	int failures = 0;
	int numChecks = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	ulm_status #(.FIFO_DEPTH(4)) dut_u (
		.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxIn(rxIn), .dcdInN(dcdInN),
		.ringInN(ringInN), .ctsInN(ctsInN), .rtsOutN(rtsOutN)
	);
	ulm_line_model line_u (.clk(clk), .rxLine(rxIn), .dcdN(dcdInN),
		.ringN(ringInN), .ctsN(ctsInN));

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// modem_status word from active-high levels and change flags
	function automatic logic [31:0] msw(input logic [2:0] lv,
		input logic dd, input logic te);
		return {24'h0, lv[2], lv[1], 1'b0, lv[0], dd, te, 2'h0};
	endfunction

	task automatic end_of_test();
		if (notes.size() != 0)
			failures++;
		$display("checks %0d failures %0d", numChecks, failures);
		if (failures == 0 && numChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		numChecks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// one APB transfer, setup then access until pready
	task automatic apb(input logic [31:0] a, input logic w,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) begin
			failures++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] v,
		input logic [31:0] m = '1, input logic e = 1'b0);
		notes.push_back('{v, m, e});
		apb(a, 1'b0, 32'h0);
	endtask

	task automatic pop(input logic [7:0] x);
		rd(A_RX, {24'h0, x});
	endtask

	// match each completed read against the oldest note
	always @(posedge clk) begin
		ulm_note_t nt;
		if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0
			&& pready === 1'b1) begin
			nt = '{32'h0, 32'h0, 1'bx};
			if (notes.size() > 0)
				nt = notes.pop_front();
			chk({pslverr, prdata & nt.mask}, {nt.err, nt.val & nt.mask});
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d [5];
		logic [2:0] old;
		logic [3:0] om;
		logic [31:0] r;
		for (int i = 0; i < 5; i++) begin
			r = rnd();
			d[i] = r[7:0] | 8'h01;
		end
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		// reset values, ignored writes, unmapped address
		apb(A_LS, 1'b1, '1);
		apb(A_MS, 1'b1, '1);
		rd(A_LS, 32'h0);
		rd(A_MS, 32'h0);
		rd(A_BAD, 32'h0, '1, 1'b1);
		// no fifo: one character, then an unread one overwritten
		line_u.frame(d[0], 1'b1, 1'b0, 1'b0, 1'b1);
		rd(A_LS, 32'h1);
		pop(d[0]);
		rd(A_LS, 32'h0);
		line_u.frame(d[1], 1'b1, 1'b0, 1'b0, 1'b1);
		line_u.frame(d[2], 1'b1, 1'b0, 1'b0, 1'b1);
		rd(A_LS, 32'h3);
		pop(d[2]);
		rd(A_LS, 32'h0);
		// even parity with a bad bit, odd parity with a good one
		apb(A_LC, 1'b1, 32'h18);
		line_u.frame(d[3], 1'b1, 1'b1, ~^d[3], 1'b1);
		rd(A_LS, 32'h5);
		pop(d[3]);
		apb(A_LC, 1'b1, 32'h08);
		line_u.frame(d[4], 1'b1, 1'b1, ~^d[4], 1'b1);
		rd(A_LS, 32'h1);
		pop(d[4]);
		// fifo: bad stop in second frame, third frame without start
		apb(A_LC, 1'b1, 32'h0);
		apb(A_FC, 1'b1, 32'h1);
		line_u.frame(d[0], 1'b1, 1'b0, 1'b0, 1'b1);
		line_u.frame(d[1], 1'b1, 1'b0, 1'b0, 1'b0);
		line_u.frame(d[2], 1'b0, 1'b0, 1'b0, 1'b1);
		rd(A_LS, 32'h1);
		pop(d[0]);
		rd(A_LS, 32'h9);
		pop(d[1]);
		rd(A_LS, 32'h1);
		pop(d[2]);
		// break, then fifo overrun with varied gaps
		line_u.frame(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
		line_u.idle(40);
		rd(A_LS, 32'hd);
		pop(8'h00);
		for (int i = 0; i < 5; i++) begin
			line_u.frame(d[i], 1'b1, 1'b0, 1'b0, 1'b1);
			line_u.idle(i * 7);
		end
		rd(A_LS, 32'h3);
		for (int i = 0; i < 4; i++)
			pop(d[i]);
		rd(A_LS, 32'h0);
		// modem pins, then loopback on the control bits
		old = 3'h7;
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			line_u.pins(r[2:0]);
			repeat (6) @(posedge clk);
			rd(A_MS, msw(~r[2:0], r[2] != old[2],
				!old[1] && r[1]));
			old = r[2:0];
		end
		apb(A_MC, 1'b1, 32'h10);
		rd(A_MS, 32'h0, 32'hffff_fff3);
		om = 4'h0;
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			line_u.pins(r[6:4]);
			apb(A_MC, 1'b1, {27'h0, 1'b1, r[3:1], 1'b0});
			repeat (6) @(posedge clk);
			rd(A_MS, msw(r[3:1], r[3] != om[3],
				om[2] && !r[2]));
			om = r[3:0];
		end
		apb(A_MC, 1'b1, 32'h2);
		repeat (6) @(posedge clk);
		rd(A_MS, msw(~r[6:4], 1'b0, 1'b0), 32'hffff_fff3);
		// carrier and ring held low across a second reset
		line_u.pins(3'h1);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (6) @(posedge clk);
		rd(A_MS, 32'hc8);
		rd(A_MS, 32'hc0);
		rd(A_LS, 32'h0);
		repeat (2) @(posedge clk);
		end_of_test();
	end
endmodule // ulm_status_tb_top
`default_nettype wire
